// >>> design/rf_tx_pkg.sv
// package for the rf transmit buffer sequencer: register map, field layout, timing
// assumes one 25 MHz clock and a plain address/strobe register port
package rf_tx_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned SETTLE_US     = 100;
  localparam int unsigned SETTLE_CYC    = (SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned BIT_CYC_DEF   = 25;
  localparam int unsigned MS_CYC        = (CLK_HZ / 1000);
  localparam int unsigned BUF_BITS      = 256;
  localparam int unsigned BUF_WORDS     = 8;

  // register offsets (word index = byte address / 4)
  localparam logic [7:0] ADDR_BUF0      = 8'h00;
  localparam logic [7:0] ADDR_CTRL      = 8'h20;
  localparam logic [7:0] ADDR_FRAME     = 8'h24;
  localparam logic [7:0] ADDR_SPACE     = 8'h28;
  localparam logic [7:0] ADDR_STATUS    = 8'h2c;
  localparam logic [7:0] ADDR_SUBBAND   = 8'h30;
  localparam logic [7:0] ADDR_FREQ      = 8'h34;

  // control and status register bit positions
  localparam int unsigned CTRL_SEND     = 0;
  localparam int unsigned CTRL_CODE_LO  = 1;
  localparam int unsigned CTRL_IRQ_EN   = 3;
  localparam int unsigned CTRL_INTERFRAME_POWERDOWN     = 4;
  localparam int unsigned CTRL_EOM      = 5;
  localparam int unsigned CTRL_DATA     = 6;
  localparam int unsigned CTRL_INVERT   = 7;
  localparam int unsigned CTRL_SPACE_EN = 8;
  localparam int unsigned STAT_DONE     = 0;
  localparam int unsigned STAT_READY    = 1;
  localparam int unsigned STAT_ACTIVE   = 2;

  typedef enum logic [1:0] {
    CODE_MANCH  = 2'h0,
    CODE_BIPH   = 2'h1,
    CODE_NRZ    = 2'h2,
    CODE_DIRECT = 2'h3
  } code_e;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_SPACE  = 7'h02,
    ST_SETTLE = 7'h04,
    ST_DATA   = 7'h08,
    ST_TAIL   = 7'h10,
    ST_DIRECT = 7'h20,
    ST_DONE   = 7'h40
  } seq_e;

  // first member is the top bit: listed from bit 8 down to send at bit 0
  typedef struct packed {
    logic       space_en;
    logic       invert;
    logic       data;
    logic       end_of_message_tail;
    logic       interframe_powerdown;
    logic       irq_en;
    code_e      code;
    logic       send;
  } ctrl_s;

  typedef struct packed {
    logic [3:0] repeat_num;
    logic [7:0] frame_bit_count;
  } frame_s;

  typedef struct packed {
    logic       xo_en;
    logic       pll_en;
    logic       pa_en;
    logic       mod;
  } rf_s;
endpackage

// >>> design/rf_bit_encoder.sv
// line encoder: turns one data bit per bit period into two half-bit levels
// assumes half_tick pulses twice per bit; load pulses with the first half
`timescale 1ns/100ps
module rf_bit_encoder
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic             i_half_tick,
  input  wire logic             i_bit,
  input  wire rf_tx_pkg::code_e i_code,
  output logic                  o_level
);
  typedef struct packed {
    logic level;
    logic second;
    logic bit_q;
  } enc_s;

  enc_s st;
  enc_s next_st;

  always_comb
  begin
    next_st = st;
    if (i_load)
    begin
      next_st.bit_q  = i_bit;
      next_st.second = 1'b0;
      case (i_code)
        rf_tx_pkg::CODE_MANCH: next_st.level = ~i_bit;
        rf_tx_pkg::CODE_BIPH:  next_st.level = ~st.level;
        default:               next_st.level = i_bit;
      endcase
    end
    else if (i_half_tick && !st.second)
    begin
      next_st.second = 1'b1;
      case (i_code)
        rf_tx_pkg::CODE_MANCH: next_st.level = st.bit_q;
        rf_tx_pkg::CODE_BIPH:  next_st.level = st.bit_q ? ~st.level : st.level;
        default:               next_st.level = st.level;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_level = st.level;
endmodule

// >>> design/rf_tx_buffer_sequencer.sv
// transmit sequencer: 256-bit buffer, encoder, power-up and frame repeat control
// assumes software keeps registers still while a buffered send is active
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
module rf_tx_buffer_sequencer
#(
  parameter int unsigned SETTLE_CYC = rf_tx_pkg::SETTLE_CYC,
  parameter int unsigned BIT_CYC    = rf_tx_pkg::BIT_CYC_DEF,
  parameter int unsigned MS_CYC     = rf_tx_pkg::MS_CYC
)
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_cal_done,
  input  wire logic [5:0]  i_cal_subband,
  input  wire logic        i_sys_active,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  output logic             o_mfo_en,
  output logic             o_xo_en,
  output logic             o_pll_en,
  output logic             o_pa_en,
  output logic             o_mod,
  output logic             o_cal_start,
  output logic [5:0]       o_subband,
  output logic [16:0]      o_freq_word
);
  typedef struct packed {
    logic [rf_tx_pkg::BUF_BITS-1:0] buffer;
    rf_tx_pkg::ctrl_s  ctrl;
    rf_tx_pkg::frame_s frame;
    logic [7:0]        space_ms;
    logic [5:0]        subband;
    logic [16:0]       freq_word;
    logic              done_flag;
    logic              ready;
    rf_tx_pkg::seq_e   seq;
    logic [31:0]       timer;
    logic [15:0]       ms_div;
    logic [8:0]        bit_idx;
    logic [3:0]        frames_left;
    logic [15:0]       half_div;
    logic              half_phase;
    logic [31:0]       rdata;
    rf_tx_pkg::rf_s    rf;
    logic              cal_start;
    logic              irq;
    logic              mfo_en;
  } state_s;

  state_s st;
  state_s next_st;

  logic       half_tick;
  logic       bit_load;
  logic       enc_level;
  logic [8:0] last_bit;

  assign half_tick = (st.seq == rf_tx_pkg::ST_DATA || st.seq == rf_tx_pkg::ST_TAIL)
                   && (st.half_div == 16'((BIT_CYC / 2) - 1));
  assign bit_load  = half_tick && st.half_phase && (st.seq == rf_tx_pkg::ST_DATA);
  assign last_bit  = {1'b0, st.frame.frame_bit_count};

  rf_bit_encoder u_enc
  (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_load      (bit_load),
    .i_half_tick (half_tick),
    .i_bit       (st.buffer[st.bit_idx[7:0]]),
    .i_code      (st.ctrl.code),
    .o_level     (enc_level)
  );

  always_comb
  begin
    next_st = st;
    next_st.cal_start = 1'b0;
    next_st.rdata = 32'h0000_0000;

    // register writes; hardware clears of send win below
    if (i_wr)
    begin
      if (i_addr < rf_tx_pkg::ADDR_CTRL && i_addr[1:0] == 2'h0)
        next_st.buffer[{i_addr[4:2], 5'h00} +: 32] = i_wdata;
      case (i_addr)
        rf_tx_pkg::ADDR_CTRL:    next_st.ctrl = rf_tx_pkg::ctrl_s'(i_wdata[8:0]);
        rf_tx_pkg::ADDR_FRAME:   next_st.frame = i_wdata[11:0];
        rf_tx_pkg::ADDR_SPACE:   next_st.space_ms = i_wdata[7:0];
        rf_tx_pkg::ADDR_STATUS:
          if (i_wdata[rf_tx_pkg::STAT_DONE])
            next_st.done_flag = 1'b0;
        rf_tx_pkg::ADDR_SUBBAND: next_st.subband = i_wdata[5:0];
        rf_tx_pkg::ADDR_FREQ:    next_st.freq_word = i_wdata[16:0];
        default: ;
      endcase
    end
    if (i_rd)
    begin
      if (i_addr < rf_tx_pkg::ADDR_CTRL && i_addr[1:0] == 2'h0)
        next_st.rdata = st.buffer[{i_addr[4:2], 5'h00} +: 32];
      case (i_addr)
        rf_tx_pkg::ADDR_CTRL:    next_st.rdata = {23'h0, st.ctrl};
        rf_tx_pkg::ADDR_FRAME:   next_st.rdata = {20'h0, st.frame};
        rf_tx_pkg::ADDR_SPACE:   next_st.rdata = {24'h0, st.space_ms};
        rf_tx_pkg::ADDR_STATUS:
          next_st.rdata = {29'h0, (st.seq != rf_tx_pkg::ST_IDLE), st.ready, st.done_flag};
        rf_tx_pkg::ADDR_SUBBAND: next_st.rdata = {26'h0, st.subband};
        rf_tx_pkg::ADDR_FREQ:    next_st.rdata = {15'h0, st.freq_word};
        default: ;
      endcase
    end

    if (i_cal_done)
      next_st.subband = i_cal_subband;

    if (st.half_div == 16'((BIT_CYC / 2) - 1))
    begin
      next_st.half_div   = 16'h0000;
      next_st.half_phase = ~st.half_phase;
    end
    else
      next_st.half_div = st.half_div + 16'h0001;

    case (st.seq)
      rf_tx_pkg::ST_IDLE:
        if (st.ctrl.send)
        begin
          next_st.frames_left = st.frame.repeat_num;
          next_st.timer       = 32'h0;
          next_st.ms_div      = 16'h0;
          next_st.ready       = 1'b0;
          next_st.rf.xo_en    = 1'b1;
          next_st.rf.pll_en   = 1'b1;
          next_st.cal_start   = 1'b1;
          if (st.ctrl.code == rf_tx_pkg::CODE_DIRECT)
            next_st.seq = rf_tx_pkg::ST_DIRECT;
          else if (st.ctrl.space_en && st.space_ms != 8'h00)
          begin
            next_st.rf  = '0;
            next_st.cal_start = 1'b0;
            next_st.seq = rf_tx_pkg::ST_SPACE;
          end
          else
            next_st.seq = rf_tx_pkg::ST_SETTLE;
        end
      rf_tx_pkg::ST_SPACE:
      begin
        next_st.rf.pa_en = 1'b0;
        if (st.ms_div == 16'(MS_CYC - 1))
        begin
          next_st.ms_div = 16'h0;
          next_st.timer  = st.timer + 32'h1;
        end
        else
          next_st.ms_div = st.ms_div + 16'h1;
        if (st.timer == {24'h0, st.space_ms})
        begin
          next_st.timer = 32'h0;
          if (!st.rf.xo_en)
          begin
            next_st.rf.xo_en  = 1'b1;
            next_st.rf.pll_en = 1'b1;
            next_st.cal_start = 1'b1;
            next_st.seq = rf_tx_pkg::ST_SETTLE;
          end
          else
          begin
            next_st.half_div = 16'((BIT_CYC / 2) - 1);
            next_st.half_phase = 1'b1;
            next_st.bit_idx = 9'h0;
            next_st.seq = rf_tx_pkg::ST_DATA;
          end
        end
      end
      rf_tx_pkg::ST_SETTLE:
      begin
        next_st.timer = st.timer + 32'h1;
        if (st.timer == SETTLE_CYC - 1)
        begin
          next_st.timer      = 32'h0;
          next_st.ready      = 1'b1;
          // first bit loads at once, so pa and data start together
          next_st.half_div   = 16'((BIT_CYC / 2) - 1);
          next_st.half_phase = 1'b1;
          next_st.bit_idx    = 9'h0;
          next_st.seq        = rf_tx_pkg::ST_DATA;
        end
      end
      rf_tx_pkg::ST_DATA:
      begin
        // pa waits one cycle for the encoder to show the first half bit
        next_st.rf.pa_en = !(bit_load && st.bit_idx == 9'h0);
        next_st.rf.mod   = enc_level;
        if (bit_load)
          next_st.bit_idx = st.bit_idx + 9'h1;
        // one cycle after the spare load: the last bit has stood a full period
        if (st.half_div == 16'h0000 && !st.half_phase && st.bit_idx == last_bit + 9'h2)
        begin
          next_st.bit_idx = 9'h0;
          if (st.ctrl.end_of_message_tail)
          begin
            next_st.timer  = 32'h0;
            next_st.rf.mod = 1'b1;
            next_st.seq    = rf_tx_pkg::ST_TAIL;
          end
          else if (st.frames_left != 4'h0)
          begin
            next_st.frames_left = st.frames_left - 4'h1;
            next_st.rf.pa_en    = 1'b0;
            next_st.seq         = rf_tx_pkg::ST_SPACE;
            if (st.ctrl.interframe_powerdown)
            begin
              next_st.rf.xo_en  = 1'b0;
              next_st.rf.pll_en = 1'b0;
            end
          end
          else
          begin
            next_st.rf.pa_en = 1'b0;
            next_st.seq      = rf_tx_pkg::ST_DONE;
          end
        end
      end
      rf_tx_pkg::ST_TAIL:
      begin
        next_st.rf.mod = 1'b1;
        next_st.timer  = st.timer + 32'h1;
        if (st.timer == 2 * BIT_CYC - 1)
        begin
          next_st.timer    = 32'h0;
          next_st.rf.pa_en = 1'b0;
          if (st.frames_left != 4'h0)
          begin
            next_st.frames_left = st.frames_left - 4'h1;
            next_st.seq = rf_tx_pkg::ST_SPACE;
            if (st.ctrl.interframe_powerdown)
            begin
              next_st.rf.xo_en  = 1'b0;
              next_st.rf.pll_en = 1'b0;
            end
          end
          else
            next_st.seq = rf_tx_pkg::ST_DONE;
        end
      end
      rf_tx_pkg::ST_DIRECT:
      begin
        next_st.timer = (st.timer == SETTLE_CYC - 1) ? st.timer : st.timer + 32'h1;
        next_st.ready = (st.timer == SETTLE_CYC - 1);
        next_st.rf.pa_en = next_st.ready;
        next_st.rf.mod = st.ctrl.data ^ st.ctrl.invert;
        if (!st.ctrl.send)
        begin
          next_st.rf  = '0;
          next_st.ready = 1'b0;
          next_st.seq = rf_tx_pkg::ST_IDLE;
        end
      end
      rf_tx_pkg::ST_DONE:
      begin
        next_st.rf        = '0;
        next_st.ready     = 1'b0;
        next_st.ctrl.send = 1'b0;
        next_st.done_flag = 1'b1;
        next_st.seq       = rf_tx_pkg::ST_IDLE;
      end
      default: next_st.seq = rf_tx_pkg::ST_IDLE;
    endcase

    next_st.irq    = next_st.done_flag & next_st.ctrl.irq_en;
    // old send kept in so the clock stays up through the clearing cycle
    next_st.mfo_en = st.ctrl.send | next_st.ctrl.send | (next_st.seq != rf_tx_pkg::ST_IDLE)
                   | i_sys_active;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st      <= '0;
      st.seq  <= rf_tx_pkg::ST_IDLE;
    end
    else
      st <= next_st;
  end

  assign o_rdata     = st.rdata;
  assign o_irq       = st.irq;
  assign o_mfo_en    = st.mfo_en;
  assign o_xo_en     = st.rf.xo_en;
  assign o_pll_en    = st.rf.pll_en;
  assign o_pa_en     = st.rf.pa_en;
  assign o_mod       = st.rf.mod;
  assign o_cal_start = st.cal_start;
  assign o_subband   = st.subband;
  assign o_freq_word = st.freq_word;

  // pa only when the synthesiser is powered
  pa_power_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_pa_en |-> o_xo_en && o_pll_en)
    else $error("pa on without oscillator");
  settle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_xo_en) |-> !o_pa_en [*8])
    else $error("pa on before settle");
  done_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.seq == rf_tx_pkg::ST_DONE |=> !st.ctrl.send && st.done_flag && !o_pa_en)
    else $error("done did not clear send");
  mfo_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.ctrl.send |=> o_mfo_en)
    else $error("mfo off while sending");
  direct_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.seq == rf_tx_pkg::ST_DIRECT && st.ctrl.send |=> o_mod == $past(st.ctrl.data ^ st.ctrl.invert))
    else $error("direct data wrong");
  interframe_powerdown_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.seq == rf_tx_pkg::ST_SPACE && st.ctrl.interframe_powerdown && st.ctrl.send |-> !o_pa_en)
    else $error("pa on in interframe");
  tail_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.seq == rf_tx_pkg::ST_TAIL |=> o_mod)
    else $error("tail not high");
  irq_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.done_flag && st.ctrl.irq_en |=> o_irq || !st.done_flag)
    else $error("irq missing");

  send_c: cover property (@(posedge i_ref_clk) st.seq == rf_tx_pkg::ST_DONE);
  repeat_c: cover property (@(posedge i_ref_clk)
    st.seq == rf_tx_pkg::ST_DATA ##1 st.seq == rf_tx_pkg::ST_SPACE);
  direct_c: cover property (@(posedge i_ref_clk) st.seq == rf_tx_pkg::ST_DIRECT && st.ready);
endmodule

// >>> dv/rf_stage_model.sv
// rf stage stand-in: calibrator answer, settle and modulation half-bit sampler
// assumes modulation edges line up with the rise of pa enable
`timescale 1ns/100ps
module rf_stage_model
(
  input  wire logic    i_ref_clk,
  input  wire logic    i_clr,
  input  wire logic    i_xo_en,
  input  wire logic    i_pll_en,
  input  wire logic    i_pa_en,
  input  wire logic    i_mod,
  input  wire logic    i_cal_start,
  output logic         o_cal_done,
  output logic [5:0]   o_cal_subband,
  output logic [511:0] o_half,
  output int           o_pa_cyc,
  output int           o_pa_on,
  output int           o_cal_n,
  output int           o_lead,
  output int           o_early
);
  int         k = 0;
  int         x = 0;
  logic [2:0] cd = 3'h0;
  always_ff @(posedge i_ref_clk)
  begin
    cd <= {cd[1:0], i_cal_start};
    k  <= i_pa_en ? k + 1 : 0;
    x  <= (i_xo_en & i_pll_en) ? x + 1 : 0;
    if (i_clr)
    begin
      o_pa_cyc <= 0;
      o_pa_on  <= 0;
      o_cal_n  <= 0;
      o_early  <= 0;
      o_half   <= '0;
    end
    else
    begin
      if (i_cal_start)
        o_cal_n <= o_cal_n + 1;
      if (i_pa_en && k == 0)
      begin
        o_pa_on <= o_pa_on + 1;
        o_lead  <= x;
      end
      if (i_pa_en && !(i_xo_en && i_pll_en))
        o_early <= o_early + 1;
      if (i_pa_en)
        o_pa_cyc <= o_pa_cyc + 1;
      if (i_pa_en && k[1:0] == 2'h2)
        o_half[k[10:2]] <= i_mod;
    end
  end
  // the result lines carry a fixed wrong value (6'h15) outside the done pulse
  assign o_cal_done    = cd[2];
  assign o_cal_subband = cd[2] ? 6'h2a : 6'h15;
endmodule

// >>> dv/rf_tx_buffer_sequencer_test.sv
// self-checking bench for the transmit sequencer
// assumes a half bit of 4 clocks and short settle and millisecond counts
`timescale 1ns/100ps
module rf_tx_buffer_sequencer_test;
  localparam int SC = 20;
  localparam int BC = 8;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, act = 0, clr = 1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic        irq, medium_freq_oscillator, xo, pll, pa, md, cs, cdn;
  logic [5:0]  csb, sb;
  logic [16:0] fw;
  logic [511:0] hf;
  int pcyc, pon, caln, lead, early, err_count = 0, cmp_count = 0, cyc = 0;
  always #20 clk = ~clk;
  rf_tx_buffer_sequencer #(.SETTLE_CYC(SC), .BIT_CYC(BC), .MS_CYC(10)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .i_cal_done(cdn), .i_cal_subband(csb), .i_sys_active(act),
    .o_rdata(rdat), .o_irq(irq), .o_mfo_en(medium_freq_oscillator), .o_xo_en(xo), .o_pll_en(pll),
    .o_pa_en(pa), .o_mod(md), .o_cal_start(cs), .o_subband(sb), .o_freq_word(fw));
  rf_stage_model u_rf (
    .i_ref_clk(clk), .i_clr(clr), .i_xo_en(xo), .i_pll_en(pll), .i_pa_en(pa),
    .i_mod(md), .i_cal_start(cs), .o_cal_done(cdn), .o_cal_subband(csb),
    .o_half(hf), .o_pa_cyc(pcyc), .o_pa_on(pon), .o_cal_n(caln), .o_lead(lead),
    .o_early(early));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 q = rdat;
  endtask
  // start a buffered send and wait for the completion interrupt
  task automatic run(input logic [31:0] ctl, input logic [31:0] frm, input logic [7:0] sp);
    int n;
    @(posedge clk) clr <= 1;
    @(posedge clk) clr <= 0;
    wreg(8'h00, 32'h000000b5);
    wreg(8'h04, 32'hffffffff);
    wreg(8'h24, frm);
    wreg(8'h28, {24'h0, sp});
    wreg(8'h20, ctl | 32'h9);
    n = 0;
    // registers left alone until the send completes
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("irq", 1, irq);
    chk("pa off", 0, pa);
    chk("early pa", 0, early);
    chk("settle", 1, lead >= SC);
    rreg(8'h20);
    chk("send clr", 0, q[0]);
    rreg(8'h2c);
    chk("done flag", 1, q[0]);
    wreg(8'h2c, 32'h1);
    rreg(8'h2c);
    chk("flag clr", 0, q[0]);
  endtask
  task automatic t_reset();
    rreg(8'h20);
    chk("ctrl rst", 0, q);
    rreg(8'h2c);
    chk("stat rst", 0, q);
    rreg(8'h3c);
    chk("unmapped", 0, q);
    chk("pa rst", 0, pa);
  endtask
  task automatic t_code(input logic [1:0] c);
    logic [7:0] b;
    logic       e0, e1, h0, h1;
    b = 8'hb5;
    run({29'h0, c, 1'b0}, 32'h7, 8'h0);
    chk("len", 8 * BC, pcyc);
    chk("cal", 1, caln);
    for (int i = 0; i < 8; i++)
    begin
      h0 = hf[2 * i];
      h1 = hf[2 * i + 1];
      e0 = c == 2'h0 ? ~b[i] : (c == 2'h2 ? b[i] : (i > 0 ? ~hf[2 * i - 1] : h0));
      e1 = c == 2'h1 ? h0 ^ b[i] : b[i];
      chk("halves", {e0, e1}, {h0, h1});
    end
  endtask
  task automatic t_repeat();
    run(32'h114, 32'h107, 8'h1);
    chk("frames", 2, pon);
    chk("repower", 2, caln);
    chk("rep len", 16 * BC, pcyc);
  endtask
  task automatic t_eom();
    run(32'h24, 32'h7, 8'h0);
    chk("eom len", 10 * BC, pcyc);
    chk("eom lvl", 4'hf, hf[19:16]);
  endtask
  task automatic t_direct();
    int n;
    wreg(8'h20, 32'h7);
    n = 0;
    q = 0;
    while (q[1] !== 1'b1 && n < 200)
    begin
      rreg(8'h2c);
      n++;
    end
    chk("ready", 1, q[1]);
    wreg(8'h20, 32'h47);
    repeat (2) @(posedge clk);
    chk("dir mod", 1, md);
    wreg(8'h20, 32'hc7);
    repeat (2) @(posedge clk);
    chk("dir inv", 0, md);
    wreg(8'h20, 32'h87);
    repeat (2) @(posedge clk);
    chk("dir inv0", 1, md);
    wreg(8'h20, 32'h6);
    repeat (4) @(posedge clk);
    chk("dir off", 0, pa);
  endtask
  task automatic t_regs();
    rreg(8'h30);
    chk("cal sb", 6'h2a, q);
    wreg(8'h30, 32'h11);
    rreg(8'h30);
    chk("sb ovr", 6'h11, q);
    chk("sb out", 6'h11, sb);
    wreg(8'h34, 32'h1abcd);
    rreg(8'h34);
    chk("freq", 17'h1abcd, q);
    chk("freq out", 17'h1abcd, fw);
    @(posedge clk) act <= 1;
    repeat (3) @(posedge clk);
    chk("mfo on", 1, medium_freq_oscillator);
    @(posedge clk) act <= 0;
    repeat (3) @(posedge clk);
    chk("mfo off", 0, medium_freq_oscillator);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_reset();
    for (int c = 0; c < 3; c++)
      t_code(c[1:0]);
    t_repeat();
    t_eom();
    t_direct();
    t_regs();
    report_and_stop();
  end
endmodule
